// [icm_bus_partner.sv]
// Purpose: other masters and slaves sharing the two-wire bus
// Assumes: pull-ups on both lines, far side on its own clock
// Notes:   pulls only when the bench commands it
`timescale 1ns/10ps
`default_nettype none
module icm_bus_partner
  import icm_pkg::*;
(
  input  wire logic linkClk,
  input  wire logic dutSclOe,
  input  wire logic dutSdaOe,
  input  wire logic pullScl,
  input  wire logic pullSda,
  output logic      sclIn,
  output logic      sdaIn
);
  icm_pins_t drive = '0;
  // -----------------------------------------------------------------
  // far-side pulls
  // -----------------------------------------------------------------
  // another party holding a line low
  always_ff @(posedge linkClk) begin
    drive.scl <= pullScl;
    drive.sda <= pullSda;
  end
  // wired-and: a released line floats high through its pull-up
  assign sclIn = !(dutSclOe | drive.scl);
  assign sdaIn = !(dutSdaOe | drive.sda);
endmodule
`default_nettype wire

// [icm_i2c_master.sv]
// Purpose: i2c master closing sequences and multi-master arbitration
// Assumes: apb slave, 250 MHz ref_clk, open-drain pins outside
// Notes:   start/restart/tx kept minimal so arbitration can act on them
`timescale 1ns/10ps
`default_nettype none
module icm_i2c_master
  import icm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        irqEnable,
  output logic             wakeReq
);

  typedef struct packed {
    icm_state_t  fsm;
    logic [6:0]  cnt;        // baud_counter
    logic [6:0]  reload;     // baud_reload_reg
    logic [7:0]  buffer;     // shift_buffer_reg
    logic [7:0]  shifter;
    logic [3:0]  bitCnt;
    logic        enable;
    logic        startEn;
    logic        restartEn;
    logic        stopEn;
    logic        ack_seq_enable;
    logic        ackData;
    logic        bufFull;
    logic        write_collision_flag;
    logic        startSeen;
    logic        stopSeen;
    logic        spIrq;
    logic        bcIrq;
    logic        sclDrvLow;
    logic        sdaDrvLow;
    icm_pins_t   prev;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        wake;
  } icm_state_s_t;

  icm_state_s_t s;
  icm_state_s_t next_s;
  icm_pins_t    pins;
  icm_pins_t    pinRaw;

  assign pinRaw.scl = sclIn;
  assign pinRaw.sda = sdaIn;

  // ---------------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------------
  icm_sync u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   (pinRaw),
    .pinOut  (pins)
  );

  // counter reached zero; shared by every timed phase
  function automatic logic baudDone(input logic [6:0] c);
    return c == ICM_ZERO7;
  endfunction

  function automatic logic [6:0] countDown(input logic [6:0] c);
    return baudDone(c) ? c : c - 7'h0_1;
  endfunction

  logic wrAcc;
  logic rdAcc;
  logic busy;
  logic startCond;
  logic stopCond;
  logic [31:0] wd;

  // ---------------------------------------------------------------------
  // bus access decode and bus-level condition detect
  // ---------------------------------------------------------------------
  always_comb begin
    wrAcc = psel & penable & pwrite & ~s.ready;
    rdAcc = psel & penable & ~pwrite & ~s.ready;
    wd    = pwdata;
    busy  = (s.fsm != ICM_IDLE);
    // edges on sda while scl high mark start and stop on the bus
    startCond = s.prev.sda & ~pins.sda & pins.scl & s.prev.scl;
    stopCond  = ~s.prev.sda & pins.sda & pins.scl & s.prev.scl;
  end

  // ---------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.prev  = pins;
    next_s.ready = 1'b0;
    next_s.err   = 1'b0;
    next_s.wake  = 1'b0;
    next_s.cnt   = countDown(s.cnt);

    // w1c clears go first, so a hardware set later in this pass wins
    if (wrAcc && paddr == ICM_OFS_FLAGS) begin
      next_s.spIrq = next_s.spIrq & ~wd[ICM_B_SPIF];
      next_s.bcIrq = next_s.bcIrq & ~wd[ICM_B_BCIF];
    end

    if (startCond) begin
      next_s.startSeen = 1'b1;
      next_s.stopSeen  = 1'b0;
    end
    if (stopCond) begin
      next_s.stopSeen  = 1'b1;
      next_s.startSeen = 1'b0;
    end
    // stop on bus raises port flag only while idle with no stop of our own pending
    if (stopCond && s.fsm == ICM_IDLE && !s.stopEn) begin
      next_s.spIrq = 1'b1;
    end

    case (s.fsm)
      ICM_IDLE: begin
        next_s.sclDrvLow = s.sclDrvLow;
        if (s.startEn) begin
          next_s.fsm = ICM_ST_CHK;
        end else if (s.restartEn) begin
          next_s.sclDrvLow = 1'b1;
          next_s.fsm       = ICM_RS_LOW;
        end else if (s.stopEn) begin
          next_s.sdaDrvLow = 1'b1;
          next_s.fsm       = ICM_SP_WSDA;
        end else if (s.ack_seq_enable) begin
          // scl low, ack data on sda
          next_s.sclDrvLow = 1'b1;
          next_s.sdaDrvLow = ~s.ackData;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_AK_LOW;
        end else if (s.bufFull) begin
          next_s.shifter   = s.buffer;
          next_s.bitCnt    = ICM_BITS;
          next_s.sdaDrvLow = ~s.buffer[7];
          next_s.sclDrvLow = 1'b1;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_TX_LOW;
        end
      end
      // lines must be high before start
      ICM_ST_CHK: begin
        if (!pins.sda || !pins.scl) begin
          next_s.bcIrq   = 1'b1;
          next_s.startEn = 1'b0;
          next_s.fsm     = ICM_IDLE;
        end else begin
          next_s.cnt = s.reload;
          next_s.fsm = ICM_ST_CNT1;
        end
      end
      ICM_ST_CNT1: begin
        if (!pins.scl && pins.sda) begin
          next_s.bcIrq   = 1'b1;
          next_s.startEn = 1'b0;
          next_s.fsm     = ICM_IDLE;
        end else if (!pins.sda || baudDone(s.cnt)) begin
          next_s.sdaDrvLow = 1'b1;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_ST_CNT2;
        end
      end
      ICM_ST_CNT2: begin
        if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b1;
          next_s.startEn   = 1'b0;
          next_s.spIrq     = 1'b1;
          next_s.fsm       = ICM_IDLE;
        end
      end
      ICM_RS_LOW: begin
        if (!pins.scl) begin
          next_s.sdaDrvLow = 1'b0;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_RS_REL;
        end
      end
      ICM_RS_REL: begin
        if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b0;
          next_s.fsm       = ICM_RS_WSCL;
        end
      end
      ICM_RS_WSCL: begin
        if (pins.scl) begin
          if (!pins.sda) begin
            next_s.bcIrq     = 1'b1;
            next_s.restartEn = 1'b0;
            next_s.fsm       = ICM_IDLE;
          end else begin
            next_s.cnt = s.reload;
            next_s.fsm = ICM_RS_CNT1;
          end
        end
      end
      ICM_RS_CNT1: begin
        if (!pins.scl && pins.sda) begin
          next_s.bcIrq     = 1'b1;
          next_s.restartEn = 1'b0;
          next_s.fsm       = ICM_IDLE;
        end else if (!pins.sda || baudDone(s.cnt)) begin
          next_s.sdaDrvLow = 1'b1;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_RS_CNT2;
        end
      end
      ICM_RS_CNT2: begin
        if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b1;
          next_s.restartEn = 1'b0;
          next_s.spIrq     = 1'b1;
          next_s.fsm       = ICM_IDLE;
        end
      end
      ICM_TX_LOW: begin
        if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b0;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_TX_HIGH;
        end
      end
      ICM_TX_HIGH: begin
        if (!pins.scl) begin
          next_s.cnt = s.reload;
        end else if (!s.sdaDrvLow && !pins.sda) begin
          next_s.bcIrq     = 1'b1;
          next_s.bufFull   = 1'b0;
          next_s.sclDrvLow = 1'b0;
          next_s.fsm       = ICM_IDLE;
        end else if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b1;
          next_s.cnt       = s.reload;
          next_s.shifter   = {s.shifter[6:0], 1'b0};
          next_s.bitCnt    = s.bitCnt - 4'h1;
          if (s.bitCnt == 4'h1) begin
            next_s.sdaDrvLow = 1'b0;
            next_s.bufFull   = 1'b0;
            next_s.fsm       = ICM_TX_ACKL;
          end else begin
            next_s.sdaDrvLow = ~s.shifter[6];
            next_s.fsm       = ICM_TX_LOW;
          end
        end
      end
      ICM_TX_ACKL: begin
        if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b0;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_TX_ACKH;
        end
      end
      ICM_TX_ACKH: begin
        if (!pins.scl) begin
          next_s.cnt = s.reload;
        end else if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b1;
          next_s.spIrq     = 1'b1;
          // completed byte wakes a sleeping core
          next_s.wake      = irqEnable;
          next_s.fsm       = ICM_IDLE;
        end
      end
      ICM_AK_LOW: begin
        if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b0;
          next_s.fsm       = ICM_AK_WSCL;
        end
      end
      ICM_AK_WSCL: begin
        if (pins.scl) begin
          next_s.cnt = s.reload;
          next_s.fsm = ICM_AK_HIGH;
        end
      end
      ICM_AK_HIGH: begin
        if (!s.sdaDrvLow && !pins.sda) begin
          next_s.bcIrq     = 1'b1;
          next_s.ack_seq_enable     = 1'b0;
          next_s.sclDrvLow = 1'b0;
          next_s.fsm       = ICM_IDLE;
        end else if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b1;
          next_s.ack_seq_enable     = 1'b0;
          next_s.fsm       = ICM_IDLE;
        end
      end
      ICM_SP_WSDA: begin
        if (!pins.sda) begin
          next_s.cnt = s.reload;
          next_s.fsm = ICM_SP_CNT;
        end
      end
      ICM_SP_CNT: begin
        if (baudDone(s.cnt)) begin
          next_s.sclDrvLow = 1'b0;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_SP_REL;
        end
      end
      ICM_SP_REL: begin
        // a bare low is the release still settling; only a fall collides
        if (s.prev.scl && !pins.scl) begin
          next_s.bcIrq     = 1'b1;
          next_s.stopEn    = 1'b0;
          next_s.sdaDrvLow = 1'b0;
          next_s.fsm       = ICM_IDLE;
        end else if (!pins.scl) begin
          // stretched: count only once scl reads high
          next_s.cnt = s.reload;
        end else if (baudDone(s.cnt)) begin
          next_s.sdaDrvLow = 1'b0;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_SP_WSEE;
        end
      end
      ICM_SP_WSEE: begin
        if (pins.sda && pins.scl) begin
          next_s.stopSeen  = 1'b1;
          next_s.startSeen = 1'b0;
          next_s.cnt       = s.reload;
          next_s.fsm       = ICM_SP_DONE;
        end else if (baudDone(s.cnt)) begin
          next_s.bcIrq  = 1'b1;
          next_s.stopEn = 1'b0;
          next_s.fsm    = ICM_IDLE;
        end
      end
      ICM_SP_DONE: begin
        if (baudDone(s.cnt)) begin
          next_s.stopEn = 1'b0;
          next_s.spIrq  = 1'b1;
          next_s.fsm    = ICM_IDLE;
        end
      end
      default: next_s.fsm = ICM_IDLE;
    endcase

    // ---------------------------------------------------------------
    // apb register access; hardware sets beat software clears
    // ---------------------------------------------------------------
    if (psel && penable && !s.ready) begin
      next_s.ready = 1'b1;
    end
    if (rdAcc) begin
      case (paddr)
        ICM_OFS_CTRL:   next_s.rdata = {24'h0, s.enable, 1'b0, s.ackData,
                                        s.ack_seq_enable, 1'b0, s.stopEn,
                                        s.restartEn, s.startEn};
        ICM_OFS_STATUS: next_s.rdata = {24'h0, s.write_collision_flag, 2'b0, s.stopSeen,
                                        s.startSeen, 2'b0, s.bufFull};
        ICM_OFS_BAUD:   next_s.rdata = {25'h0, s.reload};
        ICM_OFS_BUF:    next_s.rdata = {24'h0, s.buffer};
        ICM_OFS_FLAGS:  next_s.rdata = {30'h0, s.bcIrq, s.spIrq};
        default: begin
          next_s.rdata = 32'h0;
          next_s.err   = 1'b1;
        end
      endcase
    end
    if (wrAcc) begin
      case (paddr)
        ICM_OFS_CTRL: begin
          next_s.enable  = wd[ICM_B_ENABLE];
          next_s.ackData = wd[ICM_B_ACK_DATA_VALUE];
          // new sequences only while idle; no queueing
          if (!busy && !s.startEn && !s.restartEn && !s.stopEn &&
              !s.ack_seq_enable) begin
            next_s.startEn   = wd[ICM_B_START];
            next_s.restartEn = wd[ICM_B_RSTART];
            next_s.stopEn    = wd[ICM_B_STOP];
            next_s.ack_seq_enable     = wd[ICM_B_ACK];
          end
        end
        ICM_OFS_STATUS: begin
          if (wd[ICM_B_WRITE_COLLISION_FLAG]) begin
            next_s.write_collision_flag = 1'b0;
          end
        end
        ICM_OFS_BAUD: next_s.reload = wd[6:0];
        ICM_OFS_BUF: begin
          if (busy || s.bufFull || s.ack_seq_enable || s.stopEn ||
              s.startEn || s.restartEn) begin
            next_s.write_collision_flag = 1'b1;
          end else begin
            next_s.buffer  = wd[7:0];
            next_s.bufFull = 1'b1;
          end
        end
        ICM_OFS_FLAGS: begin
          // cleared ahead of the state machine
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.err   = 1'b1;
        end
      endcase
    end

    // disable kills transfer and seen bits
    if (!s.enable) begin
      next_s.fsm       = ICM_IDLE;
      next_s.startSeen = 1'b0;
      next_s.stopSeen  = 1'b0;
      next_s.sclDrvLow = 1'b0;
      next_s.sdaDrvLow = 1'b0;
      next_s.startEn   = 1'b0;
      next_s.restartEn = 1'b0;
      next_s.stopEn    = 1'b0;
      next_s.ack_seq_enable     = 1'b0;
      next_s.bufFull   = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // state register; reset disables the unit
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s        <= '0;
      s.fsm    <= ICM_IDLE;
      s.reload <= ICM_BAUD_RST;
      s.prev   <= '1;
    end else begin
      s <= next_s;
    end
  end

  // open-drain: only ever drive low
  assign sclOut  = 1'b0;
  assign sdaOut  = 1'b0;
  assign sclOe   = s.sclDrvLow;
  assign sdaOe   = s.sdaDrvLow;
  assign prdata  = s.rdata;
  assign pready  = s.ready;
  assign pslverr = s.err;
  assign wakeReq = s.wake;

endmodule
`default_nettype wire

// [icm_i2c_master_assertions.sv]
// Purpose: port-level checks for icm_i2c_master
// Assumes: single ref_clk domain, synchronous active-high reset
// Notes:   line sequences are judged by the bench, not here
`timescale 1ns/10ps
`default_nettype none
module icm_i2c_master_assertions
  import icm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        irqEnable,
  input wire logic        wakeReq
);
  // -----------------------------------------------------------------
  // answer timing, reset state and pin use
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  // one wait state, answer lasts a single cycle
  a_ready_one_wait: assert property (disable iff (sys_rst)
    psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (disable iff (sys_rst)
    pready |=> !pready) else $error("pready held");
  a_ready_cause: assert property (disable iff (sys_rst)
    pready |-> $past(psel) && $past(penable)) else $error("stray pready");
  a_err_zero: assert property (disable iff (sys_rst)
    pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error");
  // no disable here: the reset itself is the cause
  a_reset_quiet: assert property (
    sys_rst |=> !pready && !sclOe && !sdaOe) else $error("reset leak");
  a_open_drain: assert property (disable iff (sys_rst)
    sclOut == 1'b0 && sdaOut == 1'b0) else $error("pin driven high");
  a_wake_pulse: assert property (disable iff (sys_rst)
    wakeReq |=> !wakeReq) else $error("wake held");
  a_wake_enabled: assert property (disable iff (sys_rst)
    wakeReq |-> $past(irqEnable)) else $error("wake while masked");
endmodule

bind icm_i2c_master icm_i2c_master_assertions u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclOut(sclOut),
  .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqEnable(irqEnable),
  .wakeReq(wakeReq));
`default_nettype wire

// [icm_i2c_master_test.sv]
// Purpose: self-checking bench for icm_i2c_master
// Assumes: pull-ups on both lines, partner pulls on command
// Notes:   expectations follow the register map in icm_pkg
`timescale 1ns/10ps
`default_nettype none
module icm_i2c_master_test
  import icm_pkg::*;
;
  localparam logic [31:0] NIL = 32'h0000_0000;
  logic        ref_clk = 1'b0;
  logic        linkClk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        irqEnable = 1'b1;
  logic        pullScl = 1'b0;
  logic        pullSda = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = NIL;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic        errv;
  logic        pready, pslverr, sclIn, sclOut, sclOe, sdaIn, sdaOut;
  logic        sdaOe, wakeReq;
  int          badCount = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          wakes = 0;

  always #2 ref_clk = ~ref_clk;
  // far side clock, unrelated in phase
  initial begin
    #1.3;
    forever #16 linkClk = ~linkClk;
  end

  icm_i2c_master DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .irqEnable(irqEnable), .wakeReq(wakeReq));
  icm_bus_partner u_far (.linkClk(linkClk), .dutSclOe(sclOe),
    .dutSdaOe(sdaOe), .pullScl(pullScl), .pullSda(pullSda),
    .sclIn(sclIn), .sdaIn(sdaIn));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one transfer; waits on pready, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitReg(input logic [7:0] a, input logic [31:0] m, v);
    int n;
    n = 0;
    apb(1'b0, a, NIL);
    while ((rdv & m) !== v && n < 300) begin
      n++;
      apb(1'b0, a, NIL);
    end
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  // reset values and an unmapped read
  task automatic t_reset;
    apb(1'b0, ICM_OFS_STATUS, NIL);
    check("status", rdv, NIL);
    apb(1'b0, ICM_OFS_BAUD, NIL);
    check("baud", rdv, 32'h0000_0009);
    apb(1'b0, 8'h20, NIL);
    check("unmapped", {errv, rdv[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h24, NIL);
    check("unmapped wr", 32'(errv), 32'h0000_0001);
  endtask
  // not-acknowledge with a buffer write in the middle
  task automatic t_ack;
    apb(1'b1, ICM_OFS_CTRL, 32'h0000_00A0); // ack data set first
    apb(1'b1, ICM_OFS_CTRL, 32'h0000_00B0);
    repeat (3) @(posedge ref_clk);
    check("ack pins", 32'({sclOe, sdaOe}), 32'h0000_0002);
    apb(1'b1, ICM_OFS_BUF, 32'h0000_0055);
    apb(1'b0, ICM_OFS_STATUS, NIL);
    check("write_collision_flag", rdv & 32'h0000_0081, 32'h0000_0080);
    waitReg(ICM_OFS_CTRL, 32'h0000_0010, NIL);
    check("ack end", rdv & 32'h0000_0010, NIL);
    check("ack scl", 32'({sclOe, sdaOe}), 32'h0000_0002);
    apb(1'b1, ICM_OFS_STATUS, 32'h0000_0080);
    apb(1'b0, ICM_OFS_STATUS, NIL);
    check("write_collision_flag clr", rdv & 32'h0000_0080, NIL);
  endtask
  // stop after the acknowledge, scl still held low
  task automatic t_stop;
    apb(1'b1, ICM_OFS_CTRL, 32'h0000_0084);
    repeat (3) @(posedge ref_clk);
    check("stop sda", 32'({sclOe, sdaOe}), 32'h0000_0003);
    waitReg(ICM_OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    check("stop seen", rdv & 32'h0000_0010, 32'h0000_0010);
    check("stop pins", 32'({sclOe, sdaOe}), NIL);
    waitReg(ICM_OFS_CTRL, 32'h0000_0004, NIL);
    apb(1'b0, ICM_OFS_FLAGS, NIL);
    check("stop flag", rdv, 32'h0000_0001);
    apb(1'b1, ICM_OFS_FLAGS, 32'h0000_0003);
  endtask
  // far side keeps sda low through a stop, then lets go
  task automatic t_stop_coll;
    pullSda <= 1'b1;
    apb(1'b1, ICM_OFS_CTRL, 32'h0000_0084);
    waitReg(ICM_OFS_FLAGS, 32'h0000_0002, 32'h0000_0002);
    check("stop coll", rdv & 32'h0000_0002, 32'h0000_0002);
    apb(1'b0, ICM_OFS_CTRL, NIL);
    check("stop abort", rdv & 32'h0000_0004, NIL);
    check("coll pins", 32'({sclOe, sdaOe}), NIL);
    pullSda <= 1'b0;
    waitReg(ICM_OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
    check("bus stop", rdv & 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, ICM_OFS_FLAGS, 32'h0000_0003);
  endtask
  // start while another party holds scl low
  task automatic t_start_coll;
    apb(1'b0, ICM_OFS_STATUS, NIL);
    check("bus free", rdv & 32'h0000_0018, 32'h0000_0010);
    pullScl <= 1'b1;
    repeat (20) @(posedge ref_clk);
    apb(1'b1, ICM_OFS_CTRL, 32'h0000_0081);
    waitReg(ICM_OFS_FLAGS, 32'h0000_0002, 32'h0000_0002);
    check("start coll", rdv & 32'h0000_0002, 32'h0000_0002);
    apb(1'b0, ICM_OFS_CTRL, NIL);
    check("start abort", rdv & 32'h0000_0001, NIL);
    pullScl <= 1'b0;
    apb(1'b1, ICM_OFS_FLAGS, 32'h0000_0003);
  endtask
  // clean start, then a repeated start; each ends with the port flag
  task automatic t_start_rs;
    repeat (20) @(posedge ref_clk);
    apb(1'b1, ICM_OFS_CTRL, 32'h0000_0081);
    waitReg(ICM_OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
    check("start", 32'({rdv[1:0], sclOe, sdaOe}), 32'h0000_0007);
    apb(1'b1, ICM_OFS_FLAGS, 32'h0000_0003);
    apb(1'b1, ICM_OFS_CTRL, 32'h0000_0082);
    waitReg(ICM_OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
    check("restart", 32'({rdv[1:0], sclOe, sdaOe}), 32'h0000_0007);
    apb(1'b1, ICM_OFS_FLAGS, 32'h0000_0003);
  endtask
  // whole byte with wake, then a byte lost to a sda collision
  task automatic t_tx;
    int n;
    n = 0;
    apb(1'b1, ICM_OFS_BUF, NIL);
    while (wakeReq !== 1'b1 && n < 3000) begin
      n++;
      @(posedge ref_clk);
    end
    check("wake", 32'(wakeReq), 32'h0000_0001);
    apb(1'b1, ICM_OFS_FLAGS, 32'h0000_0003);
    // masked: a completed byte must not wake
    irqEnable <= 1'b0;
    apb(1'b1, ICM_OFS_BUF, NIL);
    waitReg(ICM_OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
    check("masked wake", wakes, 32'h0000_0001);
    irqEnable <= 1'b1;
    apb(1'b1, ICM_OFS_FLAGS, 32'h0000_0003);
    pullSda <= 1'b1;
    apb(1'b1, ICM_OFS_BUF, 32'h0000_00FF);
    waitReg(ICM_OFS_FLAGS, 32'h0000_0002, 32'h0000_0002);
    check("tx coll", rdv & 32'h0000_0002, 32'h0000_0002);
    apb(1'b0, ICM_OFS_STATUS, NIL);
    check("tx full", rdv & 32'h0000_0001, NIL);
    check("tx pins", 32'({sclOe, sdaOe}), NIL);
    pullSda <= 1'b0;
  endtask

  // hang guard, far above the longest expected run
  always @(posedge ref_clk) begin
    cycles++;
    wakes += int'(wakeReq === 1'b1);
    if (cycles == 40000) begin
      badCount++;
      wrap_up;
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_ack;
    t_stop;
    t_stop_coll;
    t_start_coll;
    t_start_rs;
    t_tx;
    wrap_up;
  end
endmodule
`default_nettype wire

// [icm_pkg.sv]
// Purpose: shared constants and types for the i2c master closing/arbitration
// Assumes: 32-bit apb, word-aligned registers
// Notes:   offsets and field positions live here only
package icm_pkg;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] ICM_OFS_CTRL   = 8'h00; // control_reg_two
  localparam logic [7:0] ICM_OFS_STATUS = 8'h04; // port_status_reg
  localparam logic [7:0] ICM_OFS_BAUD   = 8'h08; // baud_reload_reg
  localparam logic [7:0] ICM_OFS_BUF    = 8'h0C; // shift_buffer_reg
  localparam logic [7:0] ICM_OFS_FLAGS  = 8'h10; // irq flags, w1c

  // ---------------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------------
  localparam int ICM_B_START  = 0;
  localparam int ICM_B_RSTART = 1;
  localparam int ICM_B_STOP   = 2;
  localparam int ICM_B_ACK    = 4;
  localparam int ICM_B_ACK_DATA_VALUE  = 5;
  localparam int ICM_B_ENABLE = 7;

  // status field positions
  localparam int ICM_B_FULL  = 0;
  localparam int ICM_B_SSEEN = 3;
  localparam int ICM_B_PSEEN = 4;
  localparam int ICM_B_WRITE_COLLISION_FLAG  = 7;

  // flag field positions
  localparam int ICM_B_SPIF = 0;
  localparam int ICM_B_BCIF = 1;

  localparam logic [6:0] ICM_BAUD_RST = 7'h0_9;
  localparam logic [6:0] ICM_ZERO7    = 7'h0_0;
  localparam logic [3:0] ICM_BITS     = 4'h0_8;

  typedef enum logic [4:0] {
    ICM_IDLE,
    ICM_ST_CHK, ICM_ST_CNT1, ICM_ST_CNT2,
    ICM_RS_LOW, ICM_RS_REL, ICM_RS_WSCL, ICM_RS_CNT1, ICM_RS_CNT2,
    ICM_TX_LOW, ICM_TX_HIGH, ICM_TX_ACKL, ICM_TX_ACKH,
    ICM_AK_LOW, ICM_AK_WSCL, ICM_AK_HIGH,
    ICM_SP_WSDA, ICM_SP_CNT, ICM_SP_REL, ICM_SP_WSEE, ICM_SP_DONE
  } icm_state_t;

  // bus pins after synchronising
  typedef struct packed {
    logic scl;
    logic sda;
  } icm_pins_t;

endpackage

// [icm_sync.sv]
// Purpose: two-flop synchroniser for the bus pins
// Assumes: pins are asynchronous to ref_clk
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module icm_sync
  import icm_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      sys_rst,
  input  wire icm_pins_t pinIn,
  output icm_pins_t      pinOut
);

  typedef struct packed {
    icm_pins_t meta;
    icm_pins_t stable;
  } icm_sync_t;

  icm_sync_t st;
  icm_sync_t next_st;

  // ---------------------------------------------------------------------
  // two stages; idle bus reads high
  // ---------------------------------------------------------------------
  always_comb begin
    next_st.meta   = pinIn;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign pinOut = st.stable;

endmodule
`default_nettype wire
